// ===== logic/sarb_pkg.sv
// Package of constants and types for the scanning converter result buffer
package sarb_pkg;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned CHAN_W        = 3;
   localparam int unsigned NUM_CHAN      = 8;
   localparam int unsigned CONV_CLKS     = 80;
   localparam int unsigned STAT_CLKS     = 8;
   localparam int unsigned STAT_EXT_CLKS = 64;
   localparam int unsigned WR_LEAD_CLKS  = 6;
   localparam int unsigned STARTUP_CLKS  = 800;
   localparam logic [6:0]  PH_W          = 7'h00;
   localparam logic [6:0]  PH_LAST       = 7'(CONV_CLKS - 1);
   localparam logic [6:0]  PH_STAT_END   = 7'(STAT_CLKS);
   localparam logic [6:0]  PH_WRITE      = 7'(CONV_CLKS - 1 - WR_LEAD_CLKS);
   localparam logic [6:0]  PH_STAT_XEND  = 7'(STAT_CLKS + STAT_EXT_CLKS);
   localparam logic [2:0]  CHAN_RESET    = 3'h0;
   localparam logic [7:0]  DATA_RESET    = 8'h00;

   typedef struct packed
   {
      logic       strobe;
      logic [2:0] addr;
   } sarb_addr_type;

   typedef struct packed
   {
      logic [7:0] data;
      logic [7:0] oe;
   } sarb_bus_type;
endpackage

// ===== logic/sarb_ctrl.sv
// Sequencer, result memory and read port of the scanning converter
`timescale 1ns/100ps
module sarb_ctrl
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   conv_clk,
   input  wire logic                   addr_latch_strobe,
   input  wire logic                   channel_addr_bit0,
   input  wire logic                   channel_addr_bit1,
   input  wire logic                   channel_addr_bit2,
   input  wire logic                   chip_sel_n,
   input  wire logic [7:0]             sar_result,
   output sarb_pkg::sarb_bus_type      read_data_bus,
   output logic                        status_n,
   output logic [2:0]                  conv_channel
);
   import sarb_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [5:0] sync_next;
   logic       clk_prev_reg;
   logic       clk_prev_next;

   always_comb
   begin
      sync_next = {conv_clk, addr_latch_strobe, chip_sel_n,
                   channel_addr_bit2, channel_addr_bit1, channel_addr_bit0};
      clk_prev_next = sync2_reg[5];
   end

   always_ff @(posedge sys_clk)
   begin
      sync1_reg    <= sync_next;
      sync2_reg    <= sync1_reg;
      clk_prev_reg <= clk_prev_next;
   end

   logic [2:0] addr_in;
   logic       cs_n_s;
   logic       strobe_s;
   logic       clk_rise;
   assign addr_in  = sync2_reg[2:0];
   assign cs_n_s   = sync2_reg[3];
   assign strobe_s = sync2_reg[4];
   assign clk_rise = sync2_reg[5] & ~clk_prev_reg;

   // ----------------------------------------------------------------
   // Address latch
   // ----------------------------------------------------------------
   logic [2:0] addr_reg;
   logic [2:0] addr_next;

   always_comb
   begin
      addr_next = addr_reg;
      if (strobe_s)
      begin
         addr_next = addr_in;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         addr_reg <= CHAN_RESET;
      else
         addr_reg <= addr_next;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   logic [6:0]  phase_reg;
   logic [6:0]  phase_next;
   logic [2:0]  chan_reg;
   logic [2:0]  chan_next;
   logic        stat_reg;
   logic        stat_next;
   logic        cap_en;
   logic        wr_en;
   logic [2:0]  wr_chan_reg;
   logic [2:0]  wr_chan_next;
   logic [7:0]  wr_data_reg;
   logic [7:0]  wr_data_next;
   logic        wr_pend_reg;
   logic        wr_pend_next;

   always_comb
   begin
      phase_next = phase_reg;
      chan_next  = chan_reg;
      stat_next  = stat_reg;
      cap_en     = 1'b0;
      if (clk_rise)
      begin
         if (phase_reg == PH_LAST)
            phase_next = PH_W;
         else
            phase_next = phase_reg + 7'h01;
         if (phase_reg == PH_WRITE)
            cap_en = 1'b1;
         if (phase_reg == PH_LAST)
         begin
            stat_next = 1'b0;
            chan_next = chan_reg - 3'h1;
         end
         if (phase_reg == PH_STAT_END - 7'h01 && wr_chan_reg != 3'h0)
            stat_next = 1'b1;
         if (phase_reg == PH_STAT_XEND - 7'h01)
            stat_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         phase_reg <= PH_W;
         chan_reg  <= CHAN_RESET;
         stat_reg  <= 1'b1;
      end
      else
      begin
         phase_reg <= phase_next;
         chan_reg  <= chan_next;
         stat_reg  <= stat_next;
      end
   end

   // ----------------------------------------------------------------
   // Write buffer
   // ----------------------------------------------------------------
   // Newest capture wins if a read spans a whole conversion
   always_comb
   begin
      wr_chan_next = wr_chan_reg;
      wr_data_next = wr_data_reg;
      wr_pend_next = wr_pend_reg;
      wr_en        = 1'b0;
      if (wr_pend_reg && cs_n_s)
      begin
         wr_en        = 1'b1;
         wr_pend_next = 1'b0;
      end
      if (cap_en)
      begin
         wr_chan_next = chan_reg;
         wr_data_next = sar_result;
         wr_pend_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wr_chan_reg <= CHAN_RESET;
         wr_data_reg <= DATA_RESET;
         wr_pend_reg <= 1'b0;
      end
      else
      begin
         wr_chan_reg <= wr_chan_next;
         wr_data_reg <= wr_data_next;
         wr_pend_reg <= wr_pend_next;
      end
   end

   // ----------------------------------------------------------------
   // Result memory and read port
   // ----------------------------------------------------------------
   logic [7:0] mem_reg [NUM_CHAN];

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : g_mem
         logic [7:0] mem_next;
         always_comb
         begin
            mem_next = mem_reg[g];
            if (wr_en && wr_chan_reg == 3'(g))
               mem_next = wr_data_reg;
         end
         always_ff @(posedge sys_clk)
         begin
            if (rst)
               mem_reg[g] <= DATA_RESET;
            else
               mem_reg[g] <= mem_next;
         end
      end
   endgenerate

   sarb_bus_type bus_reg;
   sarb_bus_type bus_next;

   always_comb
   begin
      bus_next.data = DATA_RESET;
      bus_next.oe   = 8'h00;
      if (!cs_n_s)
      begin
         bus_next.data = mem_reg[addr_reg];
         bus_next.oe   = 8'hFF;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         bus_reg <= '0;
      else
         bus_reg <= bus_next;
   end

   assign read_data_bus = bus_reg;
   assign status_n      = stat_reg;
   assign conv_channel  = chan_reg;
endmodule

// ===== tb/sarb_ctrl_sva.sv
// Checker of the result buffer read port and status output
`timescale 1ns/100ps
module sarb_ctrl_sva
(
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   conv_clk,
   input wire logic                   chip_sel_n,
   input wire sarb_pkg::sarb_bus_type read_data_bus,
   input wire logic                   status_n,
   input wire logic [2:0]             conv_channel
);
   import sarb_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic       cc_prev_reg;
   logic [6:0] low_cnt_reg;
   always_ff @(posedge sys_clk)
   begin
      cc_prev_reg <= conv_clk;
      if (rst || status_n)
         low_cnt_reg <= 7'h00;
      else if (conv_clk && !cc_prev_reg)
         low_cnt_reg <= low_cnt_reg + 7'h01;
   end
   property p_float; chip_sel_n[*4] |-> read_data_bus.oe == 8'h00; endproperty
   a_float: assert property (p_float) else $error("bus driven");
   property p_drv; !chip_sel_n[*4] |-> read_data_bus.oe == 8'hFF; endproperty
   a_drv: assert property (p_drv) else $error("bus not driven");
   property p_lat; $fell(chip_sel_n) |-> read_data_bus.oe == 8'h00 ##1
      read_data_bus.oe == 8'h00; endproperty
   a_lat: assert property (p_lat) else $error("bus early");
   property p_hold; !chip_sel_n[*5] |-> $stable(read_data_bus.data); endproperty
   a_hold: assert property (p_hold) else $error("data torn");
   property p_w8; $fell(status_n) |-> !status_n[*8]; endproperty
   a_w8: assert property (p_w8) else $error("status short");
   property p_width; $rose(status_n) |-> low_cnt_reg ==
      ((conv_channel == 3'h7) ? 7'(STAT_CLKS + STAT_EXT_CLKS) :
      7'(STAT_CLKS)); endproperty
   a_width: assert property (p_width) else $error("status width");
   property p_dec; $fell(status_n) |->
      conv_channel == 3'($past(conv_channel) - 3'h1); endproperty
   a_dec: assert property (p_dec) else $error("no decrement");
   property p_chg; $changed(conv_channel) |-> $fell(status_n); endproperty
   a_chg: assert property (p_chg) else $error("stray step");
   property p_rise; $rose(status_n) |-> $stable(conv_channel); endproperty
   a_rise: assert property (p_rise) else $error("step on rise");
endmodule
bind sarb_ctrl sarb_ctrl_sva chk_u (.sys_clk, .rst, .conv_clk, .chip_sel_n,
   .read_data_bus, .status_n, .conv_channel);

// ===== tb/sarb_host.sv
// Far side model: conversion clock and converter result
`timescale 1ns/100ps
module sarb_host
(
   output logic            conv_clk,
   output logic [7:0]      sar_result,
   output logic [3:0]      id_cnt,
   input  wire logic [2:0] conv_channel,
   input  wire logic       status_n
);
   logic [6:0] low_t_reg;
   initial conv_clk = 1'b0;
   initial low_t_reg = 7'h00;
   initial id_cnt = 4'h0;
   always #480 conv_clk = ~conv_clk;
   assign sar_result = {5'h15, conv_channel};
   // Pulse-width detector: only a long status low counts as channel 7
   always @(posedge conv_clk)
   begin
      if (status_n)
         low_t_reg <= 7'h00;
      else if (low_t_reg != 7'h7F)
         low_t_reg <= low_t_reg + 7'h01;
      if (!status_n && low_t_reg == 7'h20)
         id_cnt <= id_cnt + 4'h1;
   end
endmodule

// ===== tb/sarb_ctrl_test.sv
// Self-checking bench of the result buffer control
`timescale 1ns/100ps
module sarb_ctrl_test;
   import sarb_pkg::*;
   logic         sys_clk = 1'b0;
   logic         rst = 1'b1;
   logic         stb = 1'b1;
   logic         chip_sel_n = 1'b1;
   logic [2:0]   addr = 3'h0;
   logic         conv_clk;
   logic [7:0]   sar_result;
   sarb_bus_type read_data_bus;
   logic         status_n;
   logic [2:0]   conv_channel;
   logic [3:0]   id_cnt;
   int           error_cnt = 0;
   int           n_tests = 0;
   always #20 sys_clk = ~sys_clk;
   sarb_host host_u (.conv_clk(conv_clk), .sar_result(sar_result),
      .id_cnt(id_cnt), .conv_channel(conv_channel), .status_n(status_n));
   sarb_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .conv_clk(conv_clk),
      .addr_latch_strobe(stb), .channel_addr_bit0(addr[0]),
      .channel_addr_bit1(addr[1]), .channel_addr_bit2(addr[2]),
      .chip_sel_n(chip_sel_n), .sar_result(sar_result),
      .read_data_bus(read_data_bus), .status_n(status_n),
      .conv_channel(conv_channel));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [2:0] a, ch);
      addr = a;
      tick(3);
      chip_sel_n = 1'b0;
      tick(5);
      chk("oe", 16'(read_data_bus.oe), 16'h00FF);
      chk("data", 16'(read_data_bus.data), {8'h00, 5'h15, ch});
      chip_sel_n = 1'b1;
      tick(5);
      chk("float", 16'(read_data_bus.oe), 16'h0000);
   endtask
   task automatic t_scan;
      int   low = 0;
      int   fall = 0;
      int   low7 = 0;
      logic prev;
      logic [3:0] id0;
      prev = status_n;
      id0 = id_cnt;
      repeat (15360)
      begin
         tick(1);
         low += int'(!status_n);
         fall += int'(prev && !status_n);
         low7 += int'(!status_n && conv_channel == 3'h7);
         prev = status_n;
      end
      chk("low", 16'(low), 16'h0C00);
      chk("falls", 16'(fall), 16'h0008);
      chk("id", 16'(low7), 16'h06C0);
      chk("det", 16'(4'(id_cnt - id0)), 16'h0001);
   endtask
   task automatic t_defer;
      addr = 3'h3;
      tick(3);
      chip_sel_n = 1'b0;
      tick(2000);
      chk("hold", 16'(read_data_bus.data), {8'h00, 5'h15, 3'h3});
      chip_sel_n = 1'b1;
      tick(5);
      rd(3'h4, 3'h4);
   endtask
   task automatic t_latch;
      addr = 3'h5;
      tick(3);
      stb = 1'b0;
      tick(3);
      rd(3'h2, 3'h5);
      stb = 1'b1;
      rd(3'h2, 3'h2);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      tick(4);
      rst = 1'b0;
      tick(19200);
      t_scan;
      for (int c = 0; c < 8; c++)
         rd(3'(c), 3'(c));
      t_latch;
      t_defer;
      wrap_up;
   end
   initial
   begin
      #2000000;
      error_cnt++;
      wrap_up;
   end
endmodule
